// ---- cid_pkg.sv ----
// Purpose: Shared constants and types for the caller-id host interface
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes: Serial register reset values packed four bits per register
`default_nettype none
package cid_pkg;
  localparam int unsigned CID_SYS_HZ = 50000000;
  // Reference rate 3.57945 MHz, in Hz
  localparam int unsigned CID_REF_HZ = 3579450;
  localparam logic [25:0] CID_ACC_MOD = 26'(CID_SYS_HZ);
  localparam logic [25:0] CID_ACC_INC = 26'(CID_REF_HZ);
  localparam int unsigned CID_NREG = 8;
  localparam int unsigned CID_FRAME_BITS = 8;
  localparam logic [2:0] CID_LAST_BIT = 3'h7;
  // Register 7 in the top nibble down to register 0 in the bottom
  localparam logic [31:0] CID_REG_RST = 32'h1131_6440;
  localparam int unsigned CID_MDR_SYNC = 0;
  localparam int unsigned CID_MDR_TONE = 2;
  localparam logic [7:0] CID_OFF_STATUS = 8'h00;
  localparam logic [7:0] CID_OFF_CTRL = 8'h04;
  localparam logic [7:0] CID_OFF_RXDATA = 8'h08;
  localparam logic [7:0] CID_OFF_REGS = 8'h20;
  localparam int unsigned CID_CTRL_FLUSH = 0;
  localparam logic [1:0] CID_RESP_OKAY = 2'h0;
  localparam logic [1:0] CID_RESP_SLVERR = 2'h2;
  // Detector outputs of the analog front end, asynchronous levels
  typedef struct packed {
    logic fsk_carrier;
    logic line_pulse;
    logic call_progress_tone;
    logic alert_present;
    logic alert_qual;
    logic line_reversal;
  } cid_evt_t;
  // Byte from the demodulator, same clock domain
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cid_rxb_t;
  typedef enum logic [1:0] {
    CID_RX_IDLE = 2'b00,
    CID_RX_PEND = 2'b01,
    CID_RX_SHIFT = 2'b10
  } cid_rx_st_t;
endpackage
`default_nettype wire

// ---- cid_host_if.sv ----
// Purpose: Host-side control, serial write port and event outputs
// Assumes: Pins and front-end levels are asynchronous; two-flop synced
// Notes: Rules carried out below, one to a line
// Function
// R1 - Derive internal timing from a 3.57945 MHz reference tick.
// R2 - Host holds power-down low normally; high means low-power state.
// R3 - While reset pin is low, all serial registers return to defaults.
// R4 - Host releases reset before any register write.
// R5 - Mode high: alert detection on, FSK and call progress off, writes.
// R6 - Host pulses mode low before a write to align the frame.
// R7 - Mode low: alert detection off, FSK or call progress, data readable.
// R8 - Ring output follows the RC node through a buffer, low on ring.
// R9 - Prequalify shows alert qualification, returns high on detection.
// R10 - Powered down: detect and interrupt low on ring or line reversal.
// R11 - FSK: detect low while carrier present.
// R12 - Call progress: detect reproduces the line input as pulses.
// R13 - Alert mode: detect low while alert tone present.
// R14 - FSK: interrupt low once a received byte is latched.
// R15 - FSK: interrupt released when host reads first bit.
// R16 - Call progress: interrupt low on a tone of 200 Hz or above.
// R17 - Alert mode: interrupt low while alert tone detected.
// R18 - Serial output advances one bit per falling serial clock edge.
// R19 - Async selection streams characters; sync follows serial clock.
// R20 - Serial output high when powered down, call progress or alert.
// R21 - Host drives write data while supplying the serial clock.
// R22 - Write frame: 4 address bits then 4 data bits, LSB first.
// R23 - Eight 4-bit registers selected by the frame address.
// R24 - Write logic held reset while reset pin or mode is low.
// R25 - Mode register bit 0: 0 async output, 1 sync, resets to 0.
// R26 - Write data sampled on rising serial clock edge.
// R27 - After eight bits commit nibble and realign for next frame.
`timescale 1ns/10ps
`default_nettype none
module cid_host_if
  import cid_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_srst, // Sync reset, high
  input wire logic [7:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI
  output logic o_awready, // AXI
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI byte enables
  input wire logic i_wvalid, // AXI
  output logic o_wready, // AXI
  output logic [1:0] o_bresp, // AXI
  output logic o_bvalid, // AXI
  input wire logic i_bready, // AXI
  input wire logic [7:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI
  output logic o_arready, // AXI
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI
  output logic o_rvalid, // AXI
  input wire logic i_rready, // AXI
  input wire logic i_power_down_in, // Power-down pin
  input wire logic i_reset_n, // Device reset pin, low
  input wire logic i_mode, // Mode pin
  input wire logic i_ser_clk_n, // Host serial clock pin
  input wire logic i_host_write_data_in, // Serial write data pin
  input wire logic i_ring_in, // Ring detection input pin
  input wire logic i_ring_rc_node_n, // RC node level
  output logic o_ring_rc_node_n_o, // RC node drive, always 0
  output logic o_ring_rc_node_n_oe, // RC node pull low
  input wire cid_evt_t i_evt, // Front-end detector levels
  input wire cid_rxb_t i_rxb, // Demodulated byte
  input wire logic i_rx_async_bit, // Async character stream
  output logic o_ring_detect_out_n, // Ring detect, low
  output logic o_tone_prequalify_n, // Prequalify, low
  output logic o_signal_detect_out_n, // Detect, low
  output logic o_irq_o, // Interrupt drive, always 0
  output logic o_irq_oe, // Interrupt pull low
  output logic o_receive_data_out, // Serial receive data
  output logic [31:0] o_regs // Serial register image
);
  localparam int unsigned NS = 11;
  logic [NS-1:0] s1_r, s2_r;
  logic [NS-1:0] pin_v;
  logic pd, rst_n_s, mode_s, sclk_s, wdat_s, ring_s, rc_s;
  cid_evt_t ev;
  logic sclk_d_r;
  logic sclk_rise, sclk_fall;

  // Two flops on every asynchronous level; stage one feeds stage two only
  assign pin_v = {i_power_down_in, i_reset_n, i_mode, i_ser_clk_n,
                  i_host_write_data_in, i_ring_in, i_ring_rc_node_n,
                  i_evt[5:2]};
  always_ff @(posedge i_clk_sys) begin
    s1_r <= pin_v;
    s2_r <= s1_r;
    sclk_d_r <= s2_r[7];
  end
  assign {pd, rst_n_s, mode_s, sclk_s, wdat_s, ring_s, rc_s} = s2_r[10:4];
  // Qual and reversal get their own two-flop sync, apart from alert_present
  logic [1:0] e1_r, e2_r;
  always_ff @(posedge i_clk_sys) begin
    e1_r <= i_evt[1:0];
    e2_r <= e1_r;
  end
  assign ev = {s2_r[3:0], e2_r};
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // R1 reference tick
  // Fractional accumulator gives the mean reference rate, with jitter
  logic [25:0] acc_r, acc_nxt;
  logic ref_tick_r, ref_tick_nxt;
  always_comb begin
    acc_nxt = acc_r + CID_ACC_INC;
    ref_tick_nxt = 1'b0;
    if (acc_nxt >= CID_ACC_MOD) begin
      acc_nxt = acc_nxt - CID_ACC_MOD;
      ref_tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      acc_r <= '0;
      ref_tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      ref_tick_r <= ref_tick_nxt;
    end
  end

  // Mode decode
  logic dev_rst, wr_en, cas, tone_mode, fsk, sync_sel;
  logic [31:0] regs_r, regs_nxt;
  // R3 register reset
  assign dev_rst = i_srst | ~rst_n_s;
  // R24 write logic reset
  assign wr_en = ~dev_rst & mode_s;
  // R5 alert mode
  assign cas = ~pd & mode_s;
  // R7 FSK or call progress
  assign tone_mode = ~pd & ~mode_s & regs_r[CID_MDR_TONE];
  assign fsk = ~pd & ~mode_s & ~regs_r[CID_MDR_TONE];
  // R25 output selection
  assign sync_sel = regs_r[CID_MDR_SYNC];

  // Serial write frame
  logic [7:0] frame_r, frame_nxt, frame_new;
  logic [2:0] wcnt_r, wcnt_nxt;
  assign frame_new = {wdat_s, frame_r[7:1]};
  always_comb begin
    frame_nxt = frame_r;
    wcnt_nxt = wcnt_r;
    regs_nxt = regs_r;
    // R26 sample on rise
    if (wr_en && sclk_rise) begin
      // R22 LSB-first frame
      frame_nxt = frame_new;
      wcnt_nxt = wcnt_r + 3'h1;
      // R27 commit and realign
      if (wcnt_r == CID_LAST_BIT && !frame_new[3]) begin
        // R23 addressed nibble
        regs_nxt[frame_new[2:0]*4 +: 4] = frame_new[7:4];
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (dev_rst) regs_r <= CID_REG_RST;
    else regs_r <= regs_nxt;
    if (!wr_en) begin
      frame_r <= '0;
      wcnt_r <= '0;
    end else begin
      frame_r <= frame_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end
  assign o_regs = regs_r;

  // Receive holding register and bit shifter
  cid_rx_st_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, last_r, last_nxt;
  logic [2:0] rcnt_r, rcnt_nxt;
  logic flush;
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    rcnt_nxt = rcnt_r;
    last_nxt = last_r;
    unique case (st_r)
      CID_RX_IDLE: ;
      // R15 first bit read
      CID_RX_PEND: if (sclk_fall) begin
        st_nxt = CID_RX_SHIFT;
        sh_nxt = {1'b1, sh_r[7:1]};
        rcnt_nxt = 3'h1;
      end
      // R18 advance on fall
      CID_RX_SHIFT: if (sclk_fall) begin
        sh_nxt = {1'b1, sh_r[7:1]};
        rcnt_nxt = rcnt_r + 3'h1;
        if (rcnt_r == CID_LAST_BIT) st_nxt = CID_RX_IDLE;
      end
      default: st_nxt = CID_RX_IDLE;
    endcase
    // A new byte overrides an unread one; host lost the old one anyway
    if (i_rxb.valid && fsk) begin
      st_nxt = CID_RX_PEND;
      sh_nxt = i_rxb.data;
      last_nxt = i_rxb.data;
      rcnt_nxt = '0;
    end else if (flush || !fsk) begin
      st_nxt = CID_RX_IDLE;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r <= CID_RX_IDLE;
      sh_r <= '1;
      rcnt_r <= '0;
      last_r <= '0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      rcnt_r <= rcnt_nxt;
      last_r <= last_nxt;
    end
  end

  // Pin outputs registered, except the two open-drain drive levels tied to 0
  logic sig_n_r, sig_n_nxt, irq_r, irq_nxt, pq_n_r, pq_n_nxt;
  logic rxo_r, rxo_nxt, ring_n_r, rc_oe_r;
  always_comb begin
    sig_n_nxt = 1'b1;
    irq_nxt = 1'b0;
    pq_n_nxt = 1'b1;
    rxo_nxt = 1'b1;
    if (pd) begin
      // R10 wake events
      sig_n_nxt = ~(~ring_n_r | ev.line_reversal);
      irq_nxt = ~ring_n_r | ev.line_reversal;
    end else if (cas) begin
      // R13 alert detect
      sig_n_nxt = ~ev.alert_present;
      // R17 alert interrupt
      irq_nxt = ev.alert_present;
      // R9 prequalify
      pq_n_nxt = ~(ev.alert_qual & ~ev.alert_present);
    end else if (tone_mode) begin
      // R12 pulse train
      sig_n_nxt = ev.line_pulse;
      // R16 tone interrupt
      irq_nxt = ev.call_progress_tone;
    end else begin
      // R11 carrier detect
      sig_n_nxt = ~ev.fsk_carrier;
      // R14 byte pending
      irq_nxt = (st_r == CID_RX_PEND);
      // R19 sync or async
      if (sync_sel) rxo_nxt = (st_r == CID_RX_IDLE) ? 1'b1 : sh_r[0];
      else rxo_nxt = ref_tick_r ? i_rx_async_bit : rxo_r;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sig_n_r <= 1'b1;
      irq_r <= 1'b0;
      pq_n_r <= 1'b1;
      rxo_r <= 1'b1;
      ring_n_r <= 1'b1;
      rc_oe_r <= 1'b0;
    end else begin
      sig_n_r <= sig_n_nxt;
      irq_r <= irq_nxt;
      pq_n_r <= pq_n_nxt;
      // R20 idle high
      rxo_r <= rxo_nxt;
      // R8 ring path, kept alive in power-down
      ring_n_r <= rc_s;
      rc_oe_r <= ring_s;
    end
  end
  assign o_signal_detect_out_n = sig_n_r;
  assign o_irq_o = 1'b0;
  assign o_irq_oe = irq_r;
  assign o_tone_prequalify_n = pq_n_r;
  assign o_receive_data_out = rxo_r;
  assign o_ring_detect_out_n = ring_n_r;
  assign o_ring_rc_node_n_o = 1'b0;
  assign o_ring_rc_node_n_oe = rc_oe_r;

  // AXI4-Lite slave; write answers one cycle after both halves are held
  logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt, status;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic wr_fire, wok;
  assign wr_fire = aw_h_r & w_h_r & ~bv_r;
  assign wok = (wa_r == CID_OFF_CTRL) | (wa_r == CID_OFF_STATUS) |
               (wa_r == CID_OFF_RXDATA);
  assign flush = wr_fire & (wa_r == CID_OFF_CTRL) & i_wstrb[0] &
                 wd_r[CID_CTRL_FLUSH];
  assign status = {20'h0, pq_n_r, wcnt_r, 1'b0, (st_r == CID_RX_PEND),
                   ~ring_n_r, ~sig_n_r, irq_r, rst_n_s, mode_s, pd};
  always_comb begin
    aw_h_nxt = aw_h_r;
    w_h_nxt = w_h_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (i_awvalid && o_awready) begin
      aw_h_nxt = 1'b1;
      wa_nxt = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_h_nxt = 1'b1;
      wd_nxt = i_wdata;
    end
    if (bv_r && i_bready) bv_nxt = 1'b0;
    if (wr_fire) begin
      aw_h_nxt = 1'b0;
      w_h_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = wok ? CID_RESP_OKAY : CID_RESP_SLVERR;
    end
    if (rv_r && i_rready) rv_nxt = 1'b0;
    if (i_arvalid && o_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = CID_RESP_OKAY;
      rd_nxt = '0;
      if (i_araddr == CID_OFF_STATUS) rd_nxt = status;
      else if (i_araddr == CID_OFF_RXDATA) rd_nxt = {24'h0, last_r};
      else if (i_araddr == CID_OFF_CTRL) rd_nxt = '0;
      else if (i_araddr[7:5] == CID_OFF_REGS[7:5] && i_araddr[1:0] == 2'h0)
        rd_nxt = {28'h0, regs_r[i_araddr[4:2]*4 +: 4]};
      else rr_nxt = CID_RESP_SLVERR;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      wa_r <= '0;
      wd_r <= '0;
      rd_r <= '0;
      br_r <= CID_RESP_OKAY;
      rr_r <= CID_RESP_OKAY;
    end else begin
      aw_h_r <= aw_h_nxt;
      w_h_r <= w_h_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      rr_r <= rr_nxt;
    end
  end
  assign o_awready = ~aw_h_r & ~bv_r;
  assign o_wready = ~w_h_r & ~bv_r;
  assign o_bvalid = bv_r;
  assign o_bresp = br_r;
  assign o_arready = ~rv_r;
  assign o_rvalid = rv_r;
  assign o_rdata = rd_r;
  assign o_rresp = rr_r;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  sequence byte_in_s;
    i_rxb.valid && fsk;
  endsequence
  sequence first_read_s;
    st_r == CID_RX_PEND && sclk_fall && !i_rxb.valid && !flush && fsk;
  endsequence
  ref_spacing_a: assert property (ref_tick_r |=> !ref_tick_r [*8]) // R1
    else $error("reference ticks too close");
  reg_reset_a: assert property (!rst_n_s |=> regs_r == CID_REG_RST) // R3
    else $error("registers not at defaults");
  wr_block_a: assert property ((!wr_en && !dev_rst) |=> // R24
    $stable(regs_r) && wcnt_r == 3'h0) else $error("write while blocked");
  commit_a: assert property ((wr_en && sclk_rise && wcnt_r == CID_LAST_BIT // R27
    && !frame_new[3] && rst_n_s) |=> regs_r[$past(frame_new[2:0])*4 +: 4]
    == $past(frame_new[7:4])) else $error("nibble not committed");
  irq_set_a: assert property (byte_in_s |=> ##1 irq_r) // R14
    else $error("no interrupt after byte");
  irq_rel_a: assert property (first_read_s ##1 fsk |=> !irq_r) // R15
    else $error("interrupt not released");
  shift_a: assert property ((st_r == CID_RX_SHIFT && sclk_fall && fsk // R18
    && !i_rxb.valid && !flush) |=> sh_r[6:0] == $past(sh_r[7:1]))
    else $error("bit not advanced");
  rxo_high_a: assert property ((pd || mode_s || tone_mode) |=> rxo_r) // R20
    else $error("serial output not high");
  alert_sig_a: assert property (cas |=> // R13
    sig_n_r == !$past(ev.alert_present)) else $error("alert detect wrong");
  ring_path_a: assert property (##1 ring_n_r == $past(rc_s)) // R8
    else $error("ring output not following node");
endmodule // cid_host_if
`default_nettype wire

// ---- cid_host_model.sv ----
// Purpose: Host CPU model driving the serial write port and mode pins
// Assumes: Serial clock period 160 ns, eight system clocks
// Notes: Serial clock idles high and stands still between frames
`timescale 1ns/10ps
`default_nettype none
module cid_host_model (
  input wire logic i_clk_sys, // System clock
  output logic o_power_down_in, // Power-down pin
  output logic o_reset_n, // Device reset pin
  output logic o_mode, // Mode pin
  output logic o_ser_clk_n, // Serial clock pin
  output logic o_host_write_data_in // Serial write data pin
);
  initial begin
    o_power_down_in = 1'b0;
    o_reset_n = 1'b1;
    o_mode = 1'b1;
    o_ser_clk_n = 1'b1;
    o_host_write_data_in = 1'b0;
  end
  // Pin levels change just after an edge
  task automatic pins(input logic pd, input logic rst_n, input logic md);
    @(posedge i_clk_sys);
    o_power_down_in <= pd;
    o_reset_n <= rst_n;
    o_mode <= md;
  endtask
  task automatic half();
    repeat (4) @(posedge i_clk_sys);
  endtask
  // data set at fall, held over rise
  task automatic bit_out(input logic b);
    o_ser_clk_n <= 1'b0;
    o_host_write_data_in <= b;
    half();
    o_ser_clk_n <= 1'b1;
    half();
  endtask
  // one falling edge per read bit
  task automatic shift();
    bit_out(~o_host_write_data_in);
  endtask
  // mode pulse, then address and data LSB first
  task automatic frame(input logic [3:0] a, input logic [3:0] d);
    @(posedge i_clk_sys);
    o_mode <= 1'b0;
    half();
    o_mode <= 1'b1;
    half();
    for (int i = 0; i < 8; i++) begin
      bit_out(i < 4 ? a[i] : d[i - 4]);
    end
    o_host_write_data_in <= ~d[3]; // Line then driven to the inverse of the last data bit
  endtask
endmodule // cid_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the caller-id host interface
// Assumes: 50 MHz clock, host model clocks serial data at 160 ns
// Notes: Pins pass two-flop syncs, so checks wait a settle span
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cid_pkg::*;
  localparam logic [31:0] REG_DEF = 32'h1131_6440;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ring_in = 1'b0, async_bit = 1'b1;
  logic [31:0] wdata = 32'h0, rdata, regs, rd, exp_regs;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, rc_o, rc_oe;
  logic pd, rst_n, mode, sclk_n, ser_wdat, ring_n, pq_n, sig_n, irq_o;
  logic irq_oe, rx_out;
  cid_evt_t evt = '0;
  cid_rxb_t rxb = '0;
  int mismatches = 0;
  int samples_checked = 0;
  // Open-drain RC node with pull-up
  wire logic rc_node_n = ~rc_oe;
  always #10 clk = ~clk;
  cid_host_if u_cid_host_if (.i_clk_sys(clk), .i_srst(srst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_power_down_in(pd), .i_reset_n(rst_n), .i_mode(mode),
    .i_ser_clk_n(sclk_n), .i_host_write_data_in(ser_wdat),
    .i_ring_in(ring_in),
    .i_ring_rc_node_n(rc_node_n), .o_ring_rc_node_n_o(rc_o),
    .o_ring_rc_node_n_oe(rc_oe), .i_evt(evt), .i_rxb(rxb),
    .i_rx_async_bit(async_bit), .o_ring_detect_out_n(ring_n),
    .o_tone_prequalify_n(pq_n), .o_signal_detect_out_n(sig_n),
    .o_irq_o(irq_o), .o_irq_oe(irq_oe), .o_receive_data_out(rx_out),
    .o_regs(regs));
  cid_host_model u_cid_host_model (.i_clk_sys(clk), .o_power_down_in(pd),
    .o_reset_n(rst_n), .o_mode(mode), .o_ser_clk_n(sclk_n),
    .o_host_write_data_in(ser_wdat));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_b(input string nm, input logic seen, exp);
    chk(nm, 32'(seen), 32'(exp));
  endtask
  // Long enough for syncs and a reference tick
  task automatic settle();
    repeat (20) @(posedge clk);
  endtask
  // Both write halves offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    resp = 2'h3;
    // Waits for the answer; only the watchdog ends a hang
    forever begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    resp = 2'h3;
    forever begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask
  // Defaults, register file read, refused addresses
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      axi_rd(CID_OFF_REGS + 8'(4 * i));
      chk("reg default", rd, {28'h0, REG_DEF[4*i+:4]});
    end
    axi_rd(8'h40);
    chk("read resp", 32'(resp), 32'(CID_RESP_SLVERR));
    axi_wr(8'h44, 32'h1);
    chk("write resp", 32'(resp), 32'(CID_RESP_SLVERR));
  endtask
  // Serial frames, out-of-range address, writes under pin reset
  task automatic t_write();
    exp_regs = REG_DEF;
    u_cid_host_model.frame(4'h3, 4'ha);
    exp_regs[15:12] = 4'ha;
    u_cid_host_model.frame(4'h9, 4'h5);
    settle();
    chk("frame write", regs, exp_regs);
    axi_rd(CID_OFF_REGS + 8'hc);
    chk("reg3 read", rd, 32'ha);
    u_cid_host_model.pins(1'b0, 1'b0, 1'b1);
    u_cid_host_model.frame(4'h6, 4'hc);
    settle();
    chk("pin reset", regs, REG_DEF);
    u_cid_host_model.pins(1'b0, 1'b1, 1'b1);
  endtask
  // Async character stream and carrier detect
  task automatic t_async();
    u_cid_host_model.pins(1'b0, 1'b1, 1'b0);
    async_bit <= 1'b0;
    evt.fsk_carrier <= 1'b1;
    settle();
    chk_b("async out", rx_out, 1'b0);
    chk_b("carrier sig", sig_n, 1'b0);
    async_bit <= 1'b1;
    evt <= '0;
    settle();
    chk_b("async out", rx_out, 1'b1);
    chk_b("carrier gone", sig_n, 1'b1);
  endtask
  // Clocked read of one byte, interrupt released on first bit
  task automatic t_sync();
    logic [7:0] b;
    b = 8'h5a;
    u_cid_host_model.frame(4'h0, 4'h1);
    // Mode pin must pass its sync before the byte counts as FSK
    u_cid_host_model.pins(1'b0, 1'b1, 1'b0);
    settle();
    rxb <= {1'b1, b};
    @(posedge clk);
    rxb <= '0;
    settle();
    chk_b("byte irq", irq_oe, 1'b1);
    chk_b("first bit", rx_out, b[0]);
    axi_rd(CID_OFF_RXDATA);
    chk("rx byte", rd, {24'h0, b});
    for (int i = 0; i < 8; i++) begin
      u_cid_host_model.shift();
      if (i == 0) chk_b("irq release", irq_oe, 1'b0);
      chk_b("shift bit", rx_out, i < 7 ? b[i+1] : 1'b1);
    end
    // Second byte dropped by a control write instead of a read
    rxb <= {1'b1, ~b};
    @(posedge clk);
    rxb <= '0;
    settle();
    chk_b("byte again", irq_oe, 1'b1);
    axi_wr(CID_OFF_CTRL, 32'h1);
    settle();
    chk_b("byte flushed", irq_oe, 1'b0);
    chk_b("flush idle", rx_out, 1'b1);
  endtask
  // Call-progress pulses and tone interrupt
  task automatic t_tone();
    u_cid_host_model.frame(4'h0, 4'h4);
    u_cid_host_model.pins(1'b0, 1'b1, 1'b0);
    evt.line_pulse <= 1'b1;
    evt.call_progress_tone <= 1'b1;
    settle();
    chk_b("pulse high", sig_n, 1'b1);
    chk_b("prog irq", irq_oe, 1'b1);
    chk_b("prog out", rx_out, 1'b1);
    evt <= '0;
    settle();
    chk_b("pulse low", sig_n, 1'b0);
    chk_b("prog quiet", irq_oe, 1'b0);
  endtask
  // Alert-tone mode qualify then detect
  task automatic t_cas();
    u_cid_host_model.pins(1'b0, 1'b1, 1'b1);
    evt.alert_qual <= 1'b1;
    settle();
    chk_b("qualifying", pq_n, 1'b0);
    chk_b("no tone irq", irq_oe, 1'b0);
    evt.alert_present <= 1'b1;
    settle();
    chk_b("tone found", pq_n, 1'b1);
    chk_b("tone sig", sig_n, 1'b0);
    chk_b("tone irq", irq_oe, 1'b1);
    chk_b("alert out", rx_out, 1'b1);
    evt <= '0;
    settle();
    chk_b("tone over", irq_oe, 1'b0);
  endtask
  // Power-down events and ring path
  task automatic t_pd();
    u_cid_host_model.pins(1'b1, 1'b1, 1'b0);
    evt.line_reversal <= 1'b1;
    settle();
    chk_b("pd sig", sig_n, 1'b0);
    chk_b("pd irq", irq_oe, 1'b1);
    chk_b("irq drive", irq_o, 1'b0);
    chk_b("pd out", rx_out, 1'b1);
    evt <= '0;
    ring_in <= 1'b1;
    settle();
    chk_b("rc pull", rc_oe, 1'b1);
    chk_b("rc drive", rc_o, 1'b0);
    chk_b("ring out", ring_n, 1'b0);
    chk_b("ring sig", sig_n, 1'b0);
    ring_in <= 1'b0;
    settle();
    chk_b("ring gone", ring_n, 1'b1);
    u_cid_host_model.pins(1'b0, 1'b1, 1'b1);
  endtask
  task automatic test_done();
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_write();
    t_async();
    t_sync();
    t_tone();
    t_cas();
    t_pd();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
